// ---- hw/mawm_manager.v ----
// motor alarm and warning manager with axi4-lite register slave
`include "mawm_map.vh"
`default_nettype none
// Notes on behaviour
// - alarm removes drive, releases hold, shows code
// - external stop brakes, then releases hold
// - overload alarm within min(setting, five seconds)
// - power-on prevention only when enabled
// - panel mode, switch on run at power-up
// - external on mode, run input at power-up
// - reverse-linked mode, run input at power-up
// - mapped external fault inactive raises stop alarm
// - prevention and stop alarms clear by reset
// - reset input clears on falling edge
// - reset input ignored while run asserted
// - show no-alarm two seconds, then initial view
// - monitor clear needs run-to-standby switch move
// - prevention alarm auto-clears when run drops
// - nine alarm records, newest first, oldest dropped
// - erase alarm records, display blinks meanwhile
// - any warning asserts warning output, unmapped default
// - overheat warning, motor keeps running
// - load above level gives overload warning
// - run mapped onto asserted terminal: warning, stop
// - nine warning records, volatile, erasable
module mawm_manager #(
  parameter [19:0] CYC_PER_MS = `MAWM_CLK_KHZ
) (
  input wire core_clk,
  input wire rst_n,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire forward_run_input,
  input wire reverse_run_input,
  input wire external_fault_input,
  input wire alarmResetInput,
  input wire panelRunSwitch,
  input wire overcurrentDet,
  input wire overheatAlarmDet,
  input wire overheatWarnDet,
  input wire overvoltageDet,
  input wire undervoltageDet,
  input wire sensorDet,
  input wire overspeedDet,
  input wire eepromErrDet,
  input wire motorOverload,
  input wire [15:0] motorLoad,
  input wire motorStopped,
  input wire runMapPulse,
  input wire mappedTermHigh,
  output reg driveEnable,
  output reg instantStop,
  output reg shaftHold,
  output reg alarmActive,
  output reg warning_output,
  output reg warningTerminal,
  output reg [7:0] displayCode,
  output reg displayBlink
);
  // ----------
  // helpers
  // ----------
  function [31:0] mergeBytes;
    input [31:0] oldW;
    input [31:0] newW;
    input [3:0] strb;
    integer b;
    begin
      mergeBytes = oldW;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) mergeBytes[b*8 +: 8] = newW[b*8 +: 8];
      end
    end
  endfunction

  // history index of an address, 4'hF when outside the window
  function [3:0] histIdx;
    input [7:0] addr;
    input [7:0] base;
    begin
      if (addr[7:6] == base[7:6] && addr[1:0] == 2'h0 && addr[5:2] < `MAWM_HIST_DEPTH) histIdx = addr[5:2];
      else histIdx = 4'hF;
    end
  endfunction

  function isRegAddr;
    input [7:0] addr;
    begin
      isRegAddr = (addr == `MAWM_OFF_CFG) || (addr == `MAWM_OFF_OVLD_MS) || (addr == `MAWM_OFF_WARN_LVL) ||
                  (addr == `MAWM_OFF_CMD) || (addr == `MAWM_OFF_STATUS) || (addr == `MAWM_OFF_DISP) ||
                  (addr == `MAWM_OFF_HIST_CNT);
    end
  endfunction

  // ----------
  // axi4-lite write path
  // ----------
  reg awHeld_q, wHeld_q;
  reg [7:0] awAddr_q;
  reg [31:0] wData_q;
  reg [3:0] wStrb_q;
  reg [31:0] cfg_q;
  reg [15:0] ovldMs_q, warnLvl_q;
  wire doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;
  wire wrWritable = (awAddr_q == `MAWM_OFF_CFG) || (awAddr_q == `MAWM_OFF_OVLD_MS) ||
                    (awAddr_q == `MAWM_OFF_WARN_LVL) || (awAddr_q == `MAWM_OFF_CMD);
  wire [31:0] cmdBits = (doWrite && awAddr_q == `MAWM_OFF_CMD) ? mergeBytes(32'h00000000, wData_q, wStrb_q) :
                        32'h00000000;
  assign s_axi_awready = ~awHeld_q & ~s_axi_bvalid;
  assign s_axi_wready = ~wHeld_q & ~s_axi_bvalid;
  // 16-bit registers only take byte lanes 0 and 1
  wire [31:0] mergedLo = mergeBytes({16'h0000, (awAddr_q == `MAWM_OFF_OVLD_MS) ? ovldMs_q : warnLvl_q}, wData_q, wStrb_q);

  // address and data are caught in either order, the write fires once both are held
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      cfg_q <= `MAWM_CFG_RST;
      ovldMs_q <= `MAWM_OVLD_MS_RST;
      warnLvl_q <= `MAWM_WARN_LVL_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrWritable ? 2'h0 : 2'h2;
        if (awAddr_q == `MAWM_OFF_CFG) cfg_q <= mergeBytes(cfg_q, wData_q, wStrb_q) & 32'h0000FF3F;
        if (awAddr_q == `MAWM_OFF_OVLD_MS) ovldMs_q <= mergedLo[15:0];
        if (awAddr_q == `MAWM_OFF_WARN_LVL) warnLvl_q <= mergedLo[15:0];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------
  // configuration fields and run signal
  // ----------
  wire preventEn = cfg_q[`MAWM_CFG_PREVENT_EN];
  wire [1:0] extRunSel = cfg_q[`MAWM_CFG_EXTRUN_LO +: 2];
  wire extFaultMapped = cfg_q[`MAWM_CFG_EXT_FAULT_MAP];
  wire autoClr = cfg_q[`MAWM_CFG_AUTO_CLR];
  wire warnMapped = cfg_q[`MAWM_CFG_WARN_MAP];
  wire [7:0] initialView = cfg_q[`MAWM_CFG_VIEW_LO +: 8];
  wire extRunOn = (extRunSel != `MAWM_EXTRUN_OFF);
  wire runInputs = forward_run_input | reverse_run_input;
  wire runActive = extRunOn ? runInputs : panelRunSwitch;

  // ----------
  // millisecond tick and overload timer
  // ----------
  reg [19:0] msDiv_q;
  reg [15:0] ovldCnt_q;
  wire msTick = (msDiv_q == CYC_PER_MS - 20'd1);
  // the detection limit never exceeds five seconds
  wire [15:0] ovldLimit = (ovldMs_q <= `MAWM_OVLD_MAX_MS) ? ovldMs_q : `MAWM_OVLD_MAX_MS;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      msDiv_q <= 20'h00000;
      ovldCnt_q <= 16'h0000;
    end else begin
      msDiv_q <= msTick ? 20'h00000 : msDiv_q + 20'd1;
      if (!motorOverload) ovldCnt_q <= 16'h0000;
      else if (msTick && ovldCnt_q != 16'hFFFF) ovldCnt_q <= ovldCnt_q + 16'd1;
    end
  end

  // ----------
  // alarm causes, priority order
  // ----------
  reg puDone_q;
  reg [7:0] alarmCode_q;
  reg [7:0] causeCode;
  // power-up check runs on the first edge after reset release
  wire puCheck = ~puDone_q;
  wire preventCause = preventEn & puCheck & (extRunOn ? runInputs : panelRunSwitch);
  wire extStopCause = extFaultMapped & ~external_fault_input;
  wire ovldCause = motorOverload & (ovldCnt_q >= ovldLimit);

  always @* begin
    causeCode = `MAWM_AL_NONE;
    if (overcurrentDet) causeCode = `MAWM_AL_OVERCURRENT;
    else if (eepromErrDet) causeCode = `MAWM_AL_EEPROM;
    else if (overheatAlarmDet) causeCode = `MAWM_AL_OVERHEAT;
    else if (overvoltageDet) causeCode = `MAWM_AL_OVERVOLT;
    else if (undervoltageDet) causeCode = `MAWM_AL_UNDERVOLT;
    else if (sensorDet) causeCode = puCheck ? `MAWM_AL_SENSOR_PU : `MAWM_AL_SENSOR;
    else if (ovldCause) causeCode = `MAWM_AL_OVERLOAD;
    else if (overspeedDet) causeCode = `MAWM_AL_OVERSPEED;
    else if (preventCause) causeCode = `MAWM_AL_PREVENT;
    else if (extStopCause) causeCode = `MAWM_AL_EXT_STOP;
  end

  // ----------
  // clearing paths
  // ----------
  reg rstPrev_q, rstArmed_q, panelPrev_q, standbySeen_q;
  // power-cycle-only alarms never clear here
  wire clearable = (alarmCode_q != `MAWM_AL_OVERCURRENT) && (alarmCode_q != `MAWM_AL_EEPROM);
  wire resetFall = rstPrev_q & ~alarmResetInput & rstArmed_q & ~runActive;
  wire monitorClr = cmdBits[`MAWM_CMD_ALM_RESET] & standbySeen_q & ~panelRunSwitch;
  wire autoClr45 = (alarmCode_q == `MAWM_AL_PREVENT) &&
                   (extRunOn ? (autoClr & ~runInputs) : ~panelRunSwitch);
  wire clearNow = alarmActive & clearable & (resetFall | monitorClr | autoClr45);
  wire raiseNow = ~alarmActive & (causeCode != `MAWM_AL_NONE);

  // reset input arms only while run is off; a run assertion disarms it
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPrev_q <= 1'b0;
      rstArmed_q <= 1'b0;
      panelPrev_q <= 1'b0;
      standbySeen_q <= 1'b0;
      puDone_q <= 1'b0;
    end else begin
      puDone_q <= 1'b1;
      rstPrev_q <= alarmResetInput;
      if (runActive || !alarmResetInput) rstArmed_q <= runActive ? 1'b0 : (rstArmed_q & alarmResetInput);
      if (alarmResetInput && !runActive) rstArmed_q <= 1'b1;
      panelPrev_q <= panelRunSwitch;
      // switch move run to standby, forgotten on a new alarm or back to run
      if (raiseNow || panelRunSwitch) standbySeen_q <= 1'b0;
      if (panelPrev_q && !panelRunSwitch) standbySeen_q <= 1'b1;
    end
  end

  // ----------
  // alarm latch and drive outputs
  // ----------
  reg opErr_q;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarmActive <= 1'b0;
      alarmCode_q <= `MAWM_AL_NONE;
      instantStop <= 1'b0;
      driveEnable <= 1'b0;
      shaftHold <= 1'b0;
    end else begin
      // latched until a clear succeeds
      if (raiseNow) begin
        alarmActive <= 1'b1;
        alarmCode_q <= causeCode;
      end else if (clearNow) begin
        alarmActive <= 1'b0;
        alarmCode_q <= `MAWM_AL_NONE;
      end
      // external stop brakes instead of coasting, until the shaft is still
      if (raiseNow && causeCode == `MAWM_AL_EXT_STOP) instantStop <= 1'b1;
      else if (motorStopped || clearNow) instantStop <= 1'b0;
      // drive drops at once on an alarm, one cycle after opErr_q sets on an operation error
      driveEnable <= ~(alarmActive | raiseNow) & ~opErr_q;
      // hold survives only for the braking phase
      shaftHold <= ~(alarmActive | raiseNow) |
                   ((instantStop | (raiseNow & (causeCode == `MAWM_AL_EXT_STOP))) & ~motorStopped);
    end
  end

  // ----------
  // warnings
  // ----------
  reg wnHeat_q, wnLoad_q;
  reg [7:0] wnNewCode;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wnHeat_q <= 1'b0;
      wnLoad_q <= 1'b0;
      opErr_q <= 1'b0;
      warning_output <= 1'b0;
      warningTerminal <= 1'b0;
    end else begin
      wnHeat_q <= overheatWarnDet;
      wnLoad_q <= (motorLoad > warnLvl_q);
      // set wins over the release of the run inputs
      if (runMapPulse && mappedTermHigh) opErr_q <= 1'b1;
      else if (!runInputs) opErr_q <= 1'b0;
      warning_output <= wnHeat_q | wnLoad_q | opErr_q;
      warningTerminal <= (wnHeat_q | wnLoad_q | opErr_q) & warnMapped;
    end
  end

  // one record per cycle: simultaneous rises keep the highest priority only
  wire wnHeatRise = overheatWarnDet & ~wnHeat_q;
  wire wnLoadRise = (motorLoad > warnLvl_q) & ~wnLoad_q;
  wire wnOpRise = runMapPulse & mappedTermHigh & ~opErr_q;
  always @* begin
    wnNewCode = `MAWM_AL_NONE;
    if (wnOpRise) wnNewCode = `MAWM_WN_OPERR;
    else if (wnHeatRise) wnNewCode = `MAWM_WN_OVERHEAT;
    else if (wnLoadRise) wnNewCode = `MAWM_WN_OVERLOAD;
  end

  // ----------
  // records and erase
  // ----------
  reg [7:0] almHist [0:8];
  reg [7:0] wrnHist [0:8];
  reg [3:0] almCnt_q, wrnCnt_q;
  reg erasing_q;
  reg [11:0] eraseMs_q;
  wire eraseDone = erasing_q & msTick & (eraseMs_q == `MAWM_ERASE_MS - 12'd1);
  wire wrnErase = cmdBits[`MAWM_CMD_WRN_ERASE];
  integer i;

  // erase first, then record, so an event in the erase cycle survives
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < `MAWM_HIST_DEPTH; i = i + 1) begin
        almHist[i] <= 8'h00;
        wrnHist[i] <= 8'h00;
      end
      almCnt_q <= 4'h0;
      wrnCnt_q <= 4'h0;
      erasing_q <= 1'b0;
      eraseMs_q <= 12'h000;
    end else begin
      if (cmdBits[`MAWM_CMD_ALM_ERASE] && !erasing_q) begin
        erasing_q <= 1'b1;
        eraseMs_q <= 12'h000;
      end else if (eraseDone) begin
        erasing_q <= 1'b0;
      end else if (erasing_q && msTick) begin
        eraseMs_q <= eraseMs_q + 12'd1;
      end
      if (raiseNow) begin
        // newest at index 0, oldest falls off the end
        for (i = `MAWM_HIST_DEPTH - 1; i > 0; i = i - 1) almHist[i] <= eraseDone ? 8'h00 : almHist[i-1];
        almHist[0] <= causeCode;
        almCnt_q <= (eraseDone || almCnt_q == 4'd9) ? (eraseDone ? 4'd1 : 4'd9) : almCnt_q + 4'd1;
      end else if (eraseDone) begin
        for (i = 0; i < `MAWM_HIST_DEPTH; i = i + 1) almHist[i] <= 8'h00;
        almCnt_q <= 4'h0;
      end
      if (wnNewCode != `MAWM_AL_NONE) begin
        for (i = `MAWM_HIST_DEPTH - 1; i > 0; i = i - 1) wrnHist[i] <= wrnErase ? 8'h00 : wrnHist[i-1];
        wrnHist[0] <= wnNewCode;
        wrnCnt_q <= (wrnErase || wrnCnt_q == 4'd9) ? (wrnErase ? 4'd1 : 4'd9) : wrnCnt_q + 4'd1;
      end else if (wrnErase) begin
        for (i = 0; i < `MAWM_HIST_DEPTH; i = i + 1) wrnHist[i] <= 8'h00;
        wrnCnt_q <= 4'h0;
      end
    end
  end

  // ----------
  // display
  // ----------
  localparam [2:0] DSP_VIEW = 3'b001;
  localparam [2:0] DSP_ALARM = 3'b010;
  localparam [2:0] DSP_CLEARED = 3'b100;
  reg [2:0] dspState_q;
  reg [11:0] showMs_q;

  // a fresh alarm always wins over the cleared screen
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dspState_q <= DSP_VIEW;
      showMs_q <= 12'h000;
      displayCode <= `MAWM_AL_NONE;
      displayBlink <= 1'b0;
    end else begin
      displayBlink <= erasing_q;
      case (dspState_q)
        DSP_VIEW: begin
          displayCode <= initialView;
          if (raiseNow) dspState_q <= DSP_ALARM;
        end
        DSP_ALARM: begin
          displayCode <= alarmCode_q;
          if (clearNow) begin
            dspState_q <= DSP_CLEARED;
            showMs_q <= 12'h000;
          end
        end
        DSP_CLEARED: begin
          displayCode <= `MAWM_AL_NONE;
          if (raiseNow) dspState_q <= DSP_ALARM;
          else if (msTick && showMs_q == `MAWM_CLEAR_SHOW_MS - 12'd1) dspState_q <= DSP_VIEW;
          else if (msTick) showMs_q <= showMs_q + 12'd1;
        end
        default: dspState_q <= DSP_VIEW;
      endcase
    end
  end

  // ----------
  // axi4-lite read path
  // ----------
  reg [31:0] rdWord;
  reg rdOk;
  wire [3:0] rdAlm = histIdx(s_axi_araddr, `MAWM_OFF_ALM_HIST);
  wire [3:0] rdWrn = histIdx(s_axi_araddr, `MAWM_OFF_WRN_HIST);
  assign s_axi_arready = ~s_axi_rvalid;

  always @* begin
    rdWord = 32'h00000000;
    rdOk = isRegAddr(s_axi_araddr) || (rdAlm != 4'hF) || (rdWrn != 4'hF);
    case (s_axi_araddr)
      `MAWM_OFF_CFG: rdWord = cfg_q;
      `MAWM_OFF_OVLD_MS: rdWord = {16'h0000, ovldMs_q};
      `MAWM_OFF_WARN_LVL: rdWord = {16'h0000, warnLvl_q};
      `MAWM_OFF_STATUS: rdWord = {18'h00000, instantStop, erasing_q, opErr_q, wnLoad_q, wnHeat_q, alarmActive,
                                  alarmCode_q};
      `MAWM_OFF_DISP: rdWord = {23'h000000, displayBlink, displayCode};
      `MAWM_OFF_HIST_CNT: rdWord = {20'h00000, wrnCnt_q, 4'h0, almCnt_q};
      default: begin
        if (rdAlm != 4'hF) rdWord = {24'h000000, almHist[rdAlm]};
        else if (rdWrn != 4'hF) rdWord = {24'h000000, wrnHist[rdWrn]};
      end
    endcase
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdWord;
      s_axi_rresp <= rdOk ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // mawm_manager
`default_nettype wire

// ---- hw/mawm_map.vh ----
// constants for the motor alarm and warning manager: offsets, fields, codes, timing
`ifndef MAWM_MAP_VH
`define MAWM_MAP_VH
// ----------
// register byte offsets
// ----------
`define MAWM_OFF_CFG 8'h00
`define MAWM_OFF_OVLD_MS 8'h04
`define MAWM_OFF_WARN_LVL 8'h08
`define MAWM_OFF_CMD 8'h0C
`define MAWM_OFF_STATUS 8'h10
`define MAWM_OFF_DISP 8'h14
`define MAWM_OFF_HIST_CNT 8'h18
`define MAWM_OFF_ALM_HIST 8'h40
`define MAWM_OFF_WRN_HIST 8'h80
// ----------
// field positions and reset values
// ----------
`define MAWM_CFG_PREVENT_EN 0
`define MAWM_CFG_EXTRUN_LO 1
`define MAWM_CFG_EXT_FAULT_MAP 3
`define MAWM_CFG_AUTO_CLR 4
`define MAWM_CFG_WARN_MAP 5
`define MAWM_CFG_VIEW_LO 8
`define MAWM_CFG_RST 32'h00000111
`define MAWM_OVLD_MS_RST 16'h1388
`define MAWM_WARN_LVL_RST 16'hC000
`define MAWM_CMD_ALM_RESET 0
`define MAWM_CMD_ALM_ERASE 1
`define MAWM_CMD_WRN_ERASE 2
`define MAWM_EXTRUN_OFF 2'h0
`define MAWM_HIST_DEPTH 9
// ----------
// alarm and warning codes
// ----------
`define MAWM_AL_OVERCURRENT 8'h20
`define MAWM_AL_OVERHEAT 8'h21
`define MAWM_AL_OVERVOLT 8'h22
`define MAWM_AL_UNDERVOLT 8'h25
`define MAWM_AL_SENSOR 8'h28
`define MAWM_AL_OVERLOAD 8'h30
`define MAWM_AL_OVERSPEED 8'h31
`define MAWM_AL_EEPROM 8'h41
`define MAWM_AL_SENSOR_PU 8'h42
`define MAWM_AL_PREVENT 8'h45
`define MAWM_AL_EXT_STOP 8'h6E
`define MAWM_AL_NONE 8'h00
`define MAWM_WN_OVERHEAT 8'h21
`define MAWM_WN_OVERLOAD 8'h30
`define MAWM_WN_OPERR 8'h6C
// ----------
// timing
// ----------
`define MAWM_CLK_KHZ 250000
`define MAWM_OVLD_MAX_MS 16'd5000
`define MAWM_CLEAR_SHOW_MS 12'd2000
`define MAWM_ERASE_MS 12'd20
`endif

// ---- bench/mawm_monitor.sv ----
// pin-level checker for the motor alarm and warning manager
`default_nettype none
module mawm_monitor (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic alarmActive,
  input wire logic driveEnable,
  input wire logic shaftHold,
  input wire logic instantStop,
  input wire logic alarmResetInput,
  input wire logic panelRunSwitch,
  input wire logic overheatWarnDet,
  input wire logic [15:0] motorLoad,
  input wire logic warning_output,
  input wire logic [7:0] displayCode,
  input wire logic displayBlink
);
  timeunit 1ns;
  timeprecision 1ps;
  // -----------------------------------------
  // alarm, clear and warning relations
  // -----------------------------------------
  // one clock domain, so clocking and disable are set once
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_alarm_off; $rose(alarmActive) && !instantStop |-> !driveEnable && !shaftHold; endproperty
  a_alarm_off: assert property (p_alarm_off) else $error("alarm left drive on");
  property p_brake; instantStop |-> !driveEnable; endproperty
  a_brake: assert property (p_brake) else $error("brake with drive on");
  property p_rise_keep; alarmActive && $rose(alarmResetInput) |=> alarmActive; endproperty
  a_rise_keep: assert property (p_rise_keep) else $error("cleared on rising reset");
  // panel mode only: the switch is the run signal there
  property p_run_block; alarmActive && panelRunSwitch |=> alarmActive; endproperty
  a_run_block: assert property (p_run_block) else $error("cleared while running");
  property p_heat_warn; overheatWarnDet |-> ##2 warning_output; endproperty
  a_heat_warn: assert property (p_heat_warn) else $error("no heat warning");
  property p_load_warn; motorLoad > 16'hC000 |-> ##2 warning_output; endproperty
  a_load_warn: assert property (p_load_warn) else $error("no load warning");
  property p_latched; alarmActive |-> !driveEnable; endproperty
  a_latched: assert property (p_latched) else $error("drive during alarm");
  property p_no_alarm; $fell(alarmActive) |=> (displayCode == 8'h00) [*4]; endproperty
  a_no_alarm: assert property (p_no_alarm) else $error("no-alarm code missing");
  property p_blink; $rose(displayBlink) |-> displayBlink [*8]; endproperty
  a_blink: assert property (p_blink) else $error("blink too short");
endmodule // mawm_monitor
bind mawm_manager mawm_monitor i_mawm_monitor (.*);
`default_nettype wire

// ---- bench/mawm_ctrl_model.sv ----
// external controller model: run input and timed alarm-reset pulse
`default_nettype none
module mawm_ctrl_model #(
  parameter int HOLD = 40
) (
  input wire logic core_clk,
  input wire logic runFwd,
  input wire logic resetReq,
  output logic forward_run_input,
  output logic reverse_run_input,
  output logic alarmResetInput
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] seqCnt_q = 8'h00;
  // run drops before the pulse, since the device ignores reset during run
  always @(posedge core_clk) begin
    if (resetReq && seqCnt_q == 8'h00) begin
      seqCnt_q <= 8'(HOLD + 1);
    end else if (seqCnt_q != 8'h00) begin
      seqCnt_q <= seqCnt_q - 8'h01;
    end
  end
  assign forward_run_input = runFwd && seqCnt_q == 8'h00;
  assign reverse_run_input = 1'b0;
  assign alarmResetInput = seqCnt_q != 8'h00 && seqCnt_q <= 8'(HOLD);
endmodule // mawm_ctrl_model
`default_nettype wire

// ---- bench/mawm_manager_bench.sv ----
// self-checking bench of the motor alarm and warning manager
`include "mawm_map.vh"
`default_nettype none
module mawm_manager_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CPM = 4;
  localparam logic [7:0] CODES [5] = '{8'h31, 8'h28, 8'h25, 8'h22, 8'h21};
  logic core_clk = 1'b0, rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, displayCode, hist[$];
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrsp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, warningTerminal;
  logic external_fault_input = 1'b1, panelRunSwitch = 1'b0, overheatWarnDet = 1'b0, motorStopped = 1'b0;
  logic overcurrentDet = 1'b0, eepromErrDet = 1'b0, motorOverload = 1'b0, runMapPulse = 1'b0, mappedTermHigh = 1'b0;
  logic forward_run_input, reverse_run_input, alarmResetInput, runFwd = 1'b0, resetReq = 1'b0;
  logic driveEnable, instantStop, shaftHold, alarmActive, warning_output, displayBlink;
  logic [15:0] motorLoad = 16'h0;
  logic [4:0] det = 5'h00;
  wire overheatAlarmDet = det[4], overvoltageDet = det[3], undervoltageDet = det[2];
  wire sensorDet = det[1], overspeedDet = det[0];
  int n_mismatch = 0, total_checks = 0, seed = 32'hb3de, k;
  mawm_manager #(.CYC_PER_MS(20'(CPM))) i_mawm_manager (.*);
  mawm_ctrl_model #(.HOLD(10 * CPM)) i_mawm_ctrl_model (.core_clk(core_clk), .runFwd(runFwd), .resetReq(resetReq),
    .forward_run_input(forward_run_input), .reverse_run_input(reverse_run_input), .alarmResetInput(alarmResetInput));
  // -----------------------------------------
  // bus and compare tasks
  // -----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // each channel released only at its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), 32'(er));
  endtask
  // one-cycle detector pulse, so the cause is gone before any clear
  task automatic raise(input int n);
    @(posedge core_clk);
    det <= 5'(1 << n);
    @(posedge core_clk);
    det <= 5'h00;
    repeat (3) @(posedge core_clk);
    hist.push_front(CODES[n]);
    if (hist.size() > 9) void'(hist.pop_back());
    chk(32'({alarmActive, driveEnable, displayCode}), 32'({2'b10, CODES[n]}));
  endtask
  task automatic clr(input bit mon);
    if (mon) begin
      panelRunSwitch <= 1'b1;
      repeat (3) @(posedge core_clk);
      panelRunSwitch <= 1'b0;
      repeat (3) @(posedge core_clk);
      wr(`MAWM_OFF_CMD, 32'h1);
    end else begin
      resetReq <= 1'b1;
      @(posedge core_clk);
      resetReq <= 1'b0;
      repeat (CPM * 5) @(posedge core_clk);
      chk(32'(alarmActive), 32'h1);
      repeat (CPM * 5 + 6) @(posedge core_clk);
    end
    repeat (3) @(posedge core_clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // -----------------------------------------
  // clock, watchdog and tests
  // -----------------------------------------
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    repeat (30000) @(posedge core_clk);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    rchk(`MAWM_OFF_CFG, `MAWM_CFG_RST);
    rchk(8'h30, 32'h0, 2'h2);
    raise(3);
    wr(`MAWM_OFF_CMD, 32'h1);
    panelRunSwitch <= 1'b1;
    clr(0);
    chk(32'(alarmActive), 32'h1);
    panelRunSwitch <= 1'b0;
    clr(0);
    chk(32'({alarmActive, displayCode}), 32'h0);
    repeat (CPM * 2000) @(posedge core_clk);
    chk(32'(displayCode), 32'h01);
    $display("test clear done");
    for (int i = 0; i < 10; i++) begin
      k = $unsigned($random(seed)) % 5;
      raise(k);
      clr(k[0] ^ i[0]);
      chk(32'(alarmActive), 32'h0);
    end
    rchk(`MAWM_OFF_HIST_CNT, 32'h9);
    foreach (hist[j]) rchk(8'(`MAWM_OFF_ALM_HIST + 4 * j), 32'(hist[j]));
    wr(`MAWM_OFF_CMD, 32'h2);
    repeat (2) @(posedge core_clk);
    chk(32'(displayBlink), 32'h1);
    repeat (CPM * 20 + 4) @(posedge core_clk);
    rchk(`MAWM_OFF_HIST_CNT, 32'h0);
    $display("test records done");
    overheatWarnDet <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(32'({warning_output, driveEnable}), 32'h3);
    overheatWarnDet <= 1'b0;
    motorLoad <= 16'hC001 + 16'($unsigned($random(seed)) % 16'h3FFE);
    repeat (4) @(posedge core_clk);
    chk(32'({warning_output, driveEnable}), 32'h3);
    motorLoad <= 16'hC000;
    repeat (4) @(posedge core_clk);
    chk(32'(warning_output), 32'h0);
    runFwd <= 1'b1;
    runMapPulse <= 1'b1;
    mappedTermHigh <= 1'b1;
    @(posedge core_clk);
    runMapPulse <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(32'({warning_output, warningTerminal, driveEnable}), 32'h4);
    runFwd <= 1'b0;
    rchk(`MAWM_OFF_HIST_CNT, 32'h300);
    rchk(`MAWM_OFF_WRN_HIST, `MAWM_WN_OPERR);
    $display("test warnings done");
    external_fault_input <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk(32'(alarmActive), 32'h0);
    wr(`MAWM_OFF_CFG, `MAWM_CFG_RST | 32'h8);
    repeat (3) @(posedge core_clk);
    chk(32'({alarmActive, instantStop, displayCode}), 32'({2'b11, `MAWM_AL_EXT_STOP}));
    external_fault_input <= 1'b1;
    motorStopped <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(32'({instantStop, shaftHold}), 32'h0);
    clr(1);
    chk(32'(alarmActive), 32'h0);
    motorStopped <= 1'b0;
    wr(`MAWM_OFF_OVLD_MS, 32'h2);
    motorOverload <= 1'b1;
    repeat (CPM * 2 + 4) @(posedge core_clk);
    chk(32'({alarmActive, displayCode}), 32'({1'b1, `MAWM_AL_OVERLOAD}));
    $display("test stop done");
    rst_n <= 1'b0;
    panelRunSwitch <= 1'b1;
    motorOverload <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(32'({alarmActive, displayCode}), 32'({1'b1, `MAWM_AL_PREVENT}));
    panelRunSwitch <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk(32'(alarmActive), 32'h0);
    $display("test power-up done");
    give_verdict();
  end
endmodule // mawm_manager_bench
`default_nettype wire
